// ==== hdl/dsl_status_pkg.sv ====
// Constants, types and register map of the DSL transmit status and
// error tally block. Assumes a single 100 MHz clock and classic Wishbone.
// Function
// - Set the signaling output queue underflow flag, bit 5, when that queue is drained faster than it is refilled.
// - Set the signaling output queue overflow flag, bit 4, when that queue is refilled faster than it is drained.
// - Set the signaling input queue underflow flag, bit 3, when it is copied out faster than the host writes it.
// - Set the signaling input queue overflow flag, bit 2, when the host writes it faster than it is copied out.
// - Any of the four signaling flags shows in one combined status bit that interrupts only when its mask bit is set.
// - Payload queue underrun sets bit 1 and overflow bit 0; either one is the masked transmit error interrupt source.
// - The CRC error tally goes up by exactly one per received frame with a CRC error.
// - The error reset control clears the CRC error tally to zero.
// - Both tallies hold while the framer is unlocked or still acquiring sync.
// - A tally reaching 255 sets its own full flag in the second receive status register.
// - The far-end error tally goes up by one per received frame whose far-end indicator is low.
// - The far-end indicator is the second received indicator bit and is also readable as bit 1 of the indicator register.
// - The error reset control clears the far-end error tally to zero.
package dsl_status_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam int IDX_W = 8;
  localparam int ADR_W = 10;
  localparam int IND_W = 8;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 8'hd0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 8'hd1;
  localparam logic [IDX_W-1:0] IDX_ERR_RESET = 8'hd9;
  localparam logic [IDX_W-1:0] IDX_RX_IND_LOW = 8'he2;
  localparam logic [IDX_W-1:0] IDX_RX_STATUS_TWO = 8'he6;
  localparam logic [IDX_W-1:0] IDX_TX_FLAGS = 8'he7;
  localparam logic [IDX_W-1:0] IDX_CRC_TALLY = 8'he8;
  localparam logic [IDX_W-1:0] IDX_FAR_TALLY = 8'he9;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SIG_OUT_UNDER_BIT = 5;
  localparam int SIG_OUT_OVER_BIT = 4;
  localparam int SIG_IN_UNDER_BIT = 3;
  localparam int SIG_IN_OVER_BIT = 2;
  localparam int TX_UNDER_BIT = 1;
  localparam int TX_OVER_BIT = 0;
  localparam int IRQ_SIG_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int CRC_FULL_BIT = 0;
  localparam int FAR_FULL_BIT = 1;
  localparam int ERR_RESET_BIT = 0;
  localparam int FAR_END_IND_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] REG_RESET = 8'h00;
  localparam logic [REG_W-1:0] MASK_RESET = 8'h00;
  localparam logic [IND_W-1:0] IND_RESET = 8'hff;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    framer_unlocked_state,
    framer_acquiring_state,
    framer_locked_state,
    framer_errored_state
  } framer_state_type;

  typedef struct packed {
    logic sig_out_under;
    logic sig_out_over;
    logic sig_in_under;
    logic sig_in_over;
    logic tx_under;
    logic tx_over;
  } tx_fifo_events_type;

  typedef struct packed {
    logic frame_end;
    logic crc_error;
    logic [IND_W-1:0] indicators;
  } rx_frame_type;

endpackage

// ==== hdl/dsl_tx_status_error_counters.sv ====
// Transmit queue error flags, CRC and far-end error tallies, and the
// Wishbone slave that exposes them. Assumes all event inputs come from
// logic on clk_i as single-cycle pulses, and framer state as a level.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/1ps
module dsl_tx_status_error_counters
  import dsl_status_pkg::*;
(
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [DATA_W-1:0] wb_dat_i,
  output logic [DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire tx_fifo_events_type tx_events_i,
  input wire rx_frame_type rx_frame_i,
  input wire framer_state_type framer_state_i,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic ack_q;
  logic [DATA_W-1:0] rdata_q;
  logic [REG_W-1:0] rdata_d;
  logic req;
  logic rd_stb;
  logic wr_stb;
  logic [IDX_W-1:0] idx;
  logic [REG_W-1:0] tx_flags_q;
  logic [REG_W-1:0] tx_flags_set;
  logic [REG_W-1:0] tx_flags_clr;
  logic [REG_W-1:0] irq_mask_q;
  logic [REG_W-1:0] irq_status;
  logic [REG_W-1:0] rx_status_two_q;
  logic [REG_W-1:0] rx_status_two_set;
  logic [REG_W-1:0] rx_status_two_clr;
  logic [IND_W-1:0] rx_ind_q;
  logic err_rst_q;
  logic irq_q;
  logic count_allowed;
  logic crc_count_en;
  logic far_count_en;
  logic [REG_W-1:0] crc_tally;
  logic [REG_W-1:0] far_tally;
  logic crc_full;
  logic far_full;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  // Sticky flag update; a set in the clearing cycle survives
  function automatic logic [REG_W-1:0] sticky(
    input logic [REG_W-1:0] cur,
    input logic [REG_W-1:0] set,
    input logic [REG_W-1:0] clr
  );
    sticky = (cur & ~clr) | set;
  endfunction

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // Answers every access one cycle after the strobe, unmapped ones too
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign rd_stb = req && !wb_we_i;
  assign wr_stb = req && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[ADR_W-1:2];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  always_comb begin
    rdata_d = REG_RESET;
    case (idx)
      IDX_IRQ_STATUS: rdata_d = irq_status;
      IDX_IRQ_MASK: rdata_d = irq_mask_q;
      IDX_RX_IND_LOW: rdata_d = rx_ind_q;
      IDX_RX_STATUS_TWO: rdata_d = rx_status_two_q;
      IDX_TX_FLAGS: rdata_d = tx_flags_q;
      IDX_CRC_TALLY: rdata_d = crc_tally;
      IDX_FAR_TALLY: rdata_d = far_tally;
      default: rdata_d = REG_RESET;
    endcase
  end

  // Narrow registers sit in the low byte, upper bits read as zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= '0;
    end else if (rd_stb) begin
      rdata_q <= {{(DATA_W-REG_W){1'b0}}, rdata_d};
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_mask_q <= MASK_RESET;
    end else if (wr_stb && idx == IDX_IRQ_MASK) begin
      irq_mask_q <= wb_dat_i[REG_W-1:0];
    end
  end

  // Self-clearing, so a stuck bit cannot freeze the tallies at zero
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      err_rst_q <= 1'b0;
    end else begin
      err_rst_q <= wr_stb && idx == IDX_ERR_RESET
                   && wb_dat_i[ERR_RESET_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Transmit queue error flags
  // ----------------------------------------------------------------
  always_comb begin
    tx_flags_set = REG_RESET;
    tx_flags_set[SIG_OUT_UNDER_BIT] = tx_events_i.sig_out_under;
    tx_flags_set[SIG_OUT_OVER_BIT] = tx_events_i.sig_out_over;
    tx_flags_set[SIG_IN_UNDER_BIT] = tx_events_i.sig_in_under;
    tx_flags_set[SIG_IN_OVER_BIT] = tx_events_i.sig_in_over;
    tx_flags_set[TX_UNDER_BIT] = tx_events_i.tx_under;
    tx_flags_set[TX_OVER_BIT] = tx_events_i.tx_over;
  end

  // Cleared by reading, as the register is read-only to software
  assign tx_flags_clr = (rd_stb && idx == IDX_TX_FLAGS) ? 8'hff : 8'h00;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tx_flags_q <= REG_RESET;
    end else begin
      tx_flags_q <= sticky(tx_flags_q, tx_flags_set, tx_flags_clr);
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status and output
  // ----------------------------------------------------------------
  always_comb begin
    irq_status = REG_RESET;
    irq_status[IRQ_SIG_BIT] = tx_flags_q[SIG_OUT_UNDER_BIT]
                              | tx_flags_q[SIG_OUT_OVER_BIT]
                              | tx_flags_q[SIG_IN_UNDER_BIT]
                              | tx_flags_q[SIG_IN_OVER_BIT];
    irq_status[IRQ_TX_BIT] = tx_flags_q[TX_UNDER_BIT]
                             | tx_flags_q[TX_OVER_BIT];
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status & irq_mask_q);
    end
  end

  assign irq_o = irq_q;

  // ----------------------------------------------------------------
  // Receive indicators and tallies
  // ----------------------------------------------------------------
  // Indicator snapshot is kept in every framer state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_ind_q <= IND_RESET;
    end else if (rx_frame_i.frame_end) begin
      rx_ind_q <= rx_frame_i.indicators;
    end
  end

  assign count_allowed = framer_state_i != framer_unlocked_state
                         && framer_state_i != framer_acquiring_state;
  assign crc_count_en = rx_frame_i.frame_end && count_allowed
                        && rx_frame_i.crc_error;
  assign far_count_en = rx_frame_i.frame_end && count_allowed
                        && !rx_frame_i.indicators[FAR_END_IND_BIT];

  error_tally #(
    .WIDTH(REG_W)
  ) u_crc_tally (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(err_rst_q),
    .count_en_i(crc_count_en),
    .count_o(crc_tally),
    .full_o(crc_full)
  );

  error_tally #(
    .WIDTH(REG_W)
  ) u_far_tally (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(err_rst_q),
    .count_en_i(far_count_en),
    .count_o(far_tally),
    .full_o(far_full)
  );

  // ----------------------------------------------------------------
  // Second receive status register
  // ----------------------------------------------------------------
  always_comb begin
    rx_status_two_set = REG_RESET;
    rx_status_two_set[CRC_FULL_BIT] = crc_full;
    rx_status_two_set[FAR_FULL_BIT] = far_full;
  end

  assign rx_status_two_clr = (rd_stb && idx == IDX_RX_STATUS_TWO) ?
                             8'hff : 8'h00;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx_status_two_q <= REG_RESET;
    end else begin
      rx_status_two_q <= sticky(rx_status_two_q, rx_status_two_set,
                                rx_status_two_clr);
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_sig_out_under;
    @(posedge clk_i) disable iff (sys_rst_i)
    tx_events_i.sig_out_under |=> tx_flags_q[SIG_OUT_UNDER_BIT];
  endproperty
  a_sig_out_under: assert property (p_sig_out_under)
    else $error("output queue underflow flag not set");

  property p_sig_out_over;
    @(posedge clk_i) disable iff (sys_rst_i)
    tx_events_i.sig_out_over |=> tx_flags_q[SIG_OUT_OVER_BIT];
  endproperty
  a_sig_out_over: assert property (p_sig_out_over)
    else $error("output queue overflow flag not set");

  property p_sig_in_under;
    @(posedge clk_i) disable iff (sys_rst_i)
    tx_events_i.sig_in_under |=> tx_flags_q[SIG_IN_UNDER_BIT];
  endproperty
  a_sig_in_under: assert property (p_sig_in_under)
    else $error("input queue underflow flag not set");

  property p_sig_in_over;
    @(posedge clk_i) disable iff (sys_rst_i)
    tx_events_i.sig_in_over |=> tx_flags_q[SIG_IN_OVER_BIT];
  endproperty
  a_sig_in_over: assert property (p_sig_in_over)
    else $error("input queue overflow flag not set");

  sequence s_sig_err_raised;
    irq_mask_q[IRQ_SIG_BIT] && |tx_flags_q[SIG_OUT_UNDER_BIT:SIG_IN_OVER_BIT];
  endsequence

  property p_sig_irq;
    @(posedge clk_i) disable iff (sys_rst_i)
    s_sig_err_raised |=> irq_q;
  endproperty
  a_sig_irq: assert property (p_sig_irq)
    else $error("masked signaling error did not interrupt");

  property p_irq_gated;
    @(posedge clk_i) disable iff (sys_rst_i)
    irq_mask_q == 8'h00 |=> !irq_q;
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("interrupt with all sources masked");

  property p_tx_err;
    @(posedge clk_i) disable iff (sys_rst_i)
    (tx_events_i.tx_under || tx_events_i.tx_over)
      |=> irq_status[IRQ_TX_BIT]
          ##1 (irq_q || !$past(irq_mask_q[IRQ_TX_BIT]));
  endproperty
  a_tx_err: assert property (p_tx_err)
    else $error("payload queue error not reported");

  property p_suspend;
    @(posedge clk_i) disable iff (sys_rst_i)
    framer_state_i == framer_unlocked_state
      || framer_state_i == framer_acquiring_state
      |-> !crc_count_en && !far_count_en;
  endproperty
  a_suspend: assert property (p_suspend)
    else $error("tally enabled while framer framer_unlocked_state");

  // Watches the tally itself, so a wrong enable path cannot hide
  property p_far_source;
    @(posedge clk_i) disable iff (sys_rst_i)
    rx_frame_i.frame_end && count_allowed && !err_rst_q
      && far_tally != 8'hff
      |=> (far_tally != $past(far_tally))
          == !$past(rx_frame_i.indicators[FAR_END_IND_BIT]);
  endproperty
  a_far_source: assert property (p_far_source)
    else $error("far-end tally source wrong");

  property p_ind_view;
    @(posedge clk_i) disable iff (sys_rst_i)
    rx_frame_i.frame_end
      |=> rx_ind_q[FAR_END_IND_BIT]
          == $past(rx_frame_i.indicators[FAR_END_IND_BIT]);
  endproperty
  a_ind_view: assert property (p_ind_view)
    else $error("indicator bit one not captured");

  property p_err_reset;
    @(posedge clk_i) disable iff (sys_rst_i)
    wr_stb && idx == IDX_ERR_RESET && wb_dat_i[ERR_RESET_BIT]
      |=> ##1 crc_tally == 8'h00 && far_tally == 8'h00;
  endproperty
  a_err_reset: assert property (p_err_reset)
    else $error("tallies not cleared by error reset");

  property p_full_flag;
    @(posedge clk_i) disable iff (sys_rst_i)
    crc_full |=> rx_status_two_q[CRC_FULL_BIT];
  endproperty
  a_full_flag: assert property (p_full_flag)
    else $error("tally full flag not set");

  property p_far_full_flag;
    @(posedge clk_i) disable iff (sys_rst_i)
    far_full |=> rx_status_two_q[FAR_FULL_BIT];
  endproperty
  a_far_full_flag: assert property (p_far_full_flag)
    else $error("far-end full flag not set");

endmodule

// ==== hdl/error_tally.sv ====
// Saturating event tally with synchronous clear and a full pulse.
// Assumes count_en_i and clear_i are single-cycle pulses on clk_i.
`timescale 1ns/1ps
module error_tally
  import dsl_status_pkg::*;
#(
  parameter int WIDTH = REG_W
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic clear_i,
  input wire logic count_en_i,
  output logic [WIDTH-1:0] count_o,
  output logic full_o
);

  localparam logic [WIDTH-1:0] MAX = '1;
  localparam logic [WIDTH-1:0] NEAR_MAX = MAX - 1'b1;

  logic [WIDTH-1:0] count_q;
  logic full_q;

  // ----------------------------------------------------------------
  // Tally
  // ----------------------------------------------------------------
  // Clear wins over a count arriving in the same cycle
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count_q <= '0;
    end else if (clear_i) begin
      count_q <= '0;
    end else if (count_en_i && count_q != MAX) begin
      count_q <= WIDTH'(count_q + 1'b1);
    end
  end

  // Saturates so software never sees a wrapped, misleading small count
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      full_q <= 1'b0;
    end else begin
      full_q <= !clear_i && count_en_i && count_q == NEAR_MAX;
    end
  end

  assign count_o = count_q;
  assign full_o = full_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_tally_step;
    @(posedge clk_i) disable iff (sys_rst_i)
    count_en_i && !clear_i && count_q != MAX
      |=> count_q == WIDTH'($past(count_q) + 1'b1);
  endproperty
  a_tally_step: assert property (p_tally_step)
    else $error("tally did not step by one");

  property p_tally_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
    clear_i |=> count_q == '0 && !full_q;
  endproperty
  a_tally_clear: assert property (p_tally_clear)
    else $error("tally not cleared");

  property p_tally_full;
    @(posedge clk_i) disable iff (sys_rst_i)
    count_en_i && !clear_i && count_q == NEAR_MAX
      |=> full_q && count_q == MAX ##1 !full_q;
  endproperty
  a_tally_full: assert property (p_tally_full)
    else $error("full pulse missing at maximum");

  property p_tally_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
    !count_en_i && !clear_i |=> $stable(count_q);
  endproperty
  a_tally_hold: assert property (p_tally_hold)
    else $error("tally moved without a count");

endmodule

// ==== verif/dsl_tx_status_error_counters_tb.sv ====
// Self-checking bench for the DSL transmit status and error tally block.
// Assumes the block answers classic Wishbone and that all event inputs
// are single-cycle pulses on clk_i; the assertions sit in the design files.
`timescale 1ns/1ps
module dsl_tx_status_error_counters_tb;
  import dsl_status_pkg::*;
  // --------------------------------------------------------------
  // Signals
  // --------------------------------------------------------------
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [DATA_W-1:0] wb_dat_i = '0;
  logic [DATA_W-1:0] wb_dat_o;
  logic wb_ack_o;
  logic irq_o;
  tx_fifo_events_type tx_events_i = '0;
  rx_frame_type rx_frame_i = '0;
  framer_state_type framer_state_i = framer_unlocked_state;
  logic [DATA_W-1:0] exp_q[$];
  int fail_count = 0;
  int check_count = 0;
  int seed = 32'h2499;
  int ec = 0;
  int ef = 0;
  logic [7:0] ind;
  logic c;

  dsl_tx_status_error_counters dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tx_events_i(tx_events_i),
    .rx_frame_i(rx_frame_i), .framer_state_i(framer_state_i),
    .irq_o(irq_o)
  );

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  task automatic chk(input string what, input logic [DATA_W-1:0] e,
                     input logic [DATA_W-1:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Request held until ack is sampled; no fixed latency assumed
  task automatic wb_cycle(input logic we, input logic [IDX_W-1:0] idx,
                          input logic [7:0] d, input logic [3:0] sel);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= {idx, 2'b00};
    wb_sel_i <= sel;
    wb_dat_i <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      chk("wb_ack_o", 32'h1, 32'h0);
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [IDX_W-1:0] idx, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    wb_cycle(1'b0, idx, 8'h00, 4'hf);
  endtask

  task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] d,
                    input logic [3:0] sel);
    wb_cycle(1'b1, idx, d, sel);
  endtask

  task automatic ev(input logic [5:0] v);
    @(posedge clk_i);
    tx_events_i <= tx_fifo_events_type'(v);
    @(posedge clk_i);
    tx_events_i <= '0;
  endtask

  task automatic fr(input logic crc, input logic [7:0] d);
    @(posedge clk_i);
    rx_frame_i <= '{frame_end: 1'b1, crc_error: crc, indicators: d};
    @(posedge clk_i);
    rx_frame_i.frame_end <= 1'b0;
  endtask

  // Irq is registered one cycle behind status; three cycles is slack
  task automatic irq_chk(input logic e);
    repeat (3) @(posedge clk_i);
    chk("irq_o", {31'h0, e}, {31'h0, irq_o});
  endtask

  // --------------------------------------------------------------
  // Read monitor: oldest note against each read answer
  // --------------------------------------------------------------
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
      if (exp_q.size() == 0) begin
        chk("unexpected read", 32'h0, 32'hffffffff);
      end else begin
        chk("wb_dat_o", exp_q.pop_front(), wb_dat_o);
      end
    end
  end

  initial begin
    #(20000 * 10);
    chk("watchdog", 32'h0, 32'h1);
    end_sim();
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(IDX_TX_FLAGS, REG_RESET);
    rd(IDX_CRC_TALLY, REG_RESET);
    rd(IDX_FAR_TALLY, REG_RESET);
    rd(IDX_RX_IND_LOW, IND_RESET);
    rd(IDX_IRQ_MASK, MASK_RESET);
    rd(IDX_RX_STATUS_TWO, 8'h00);
    rd(8'h00, 8'h00);
    wr(8'h00, 8'hff, 4'hf);
    rd(8'h00, 8'h00);
    for (int b = 0; b < 6; b++) begin
      ev(6'(1 << b));
      rd(IDX_IRQ_STATUS, (b >= 2) ? 8'h01 : 8'h02);
      rd(IDX_TX_FLAGS, 8'(1 << b));
      rd(IDX_TX_FLAGS, 8'h00);
    end
    ev(6'h20);
    irq_chk(1'b0);
    wr(IDX_IRQ_MASK, 8'h01, 4'hf);
    irq_chk(1'b1);
    rd(IDX_TX_FLAGS, 8'h20);
    irq_chk(1'b0);
    ev(6'h01);
    irq_chk(1'b0);
    wr(IDX_IRQ_MASK, 8'h02, 4'hf);
    irq_chk(1'b1);
    rd(IDX_IRQ_MASK, 8'h02);
    wr(IDX_IRQ_MASK, 8'h00, 4'hf);
    irq_chk(1'b0);
    rd(IDX_TX_FLAGS, 8'h01);
    // Out of lock nothing counts, but the indicator snapshot follows
    fr(1'b1, 8'h00);
    framer_state_i <= framer_acquiring_state;
    fr(1'b1, 8'hfd);
    rd(IDX_CRC_TALLY, 8'h00);
    rd(IDX_FAR_TALLY, 8'h00);
    rd(IDX_RX_IND_LOW, 8'hfd);
    framer_state_i <= framer_locked_state;
    for (int i = 0; i < 20; i++) begin
      ind = 8'($random(seed));
      c = 1'($random(seed));
      ec += c;
      ef += !ind[FAR_END_IND_BIT];
      fr(c, ind);
    end
    rd(IDX_CRC_TALLY, 8'(ec));
    rd(IDX_FAR_TALLY, 8'(ef));
    rd(IDX_RX_IND_LOW, ind);
    wr(IDX_ERR_RESET, 8'h01, 4'he);
    wr(IDX_CRC_TALLY, 8'h55, 4'hf);
    rd(IDX_CRC_TALLY, 8'(ec));
    wr(IDX_ERR_RESET, 8'h01, 4'hf);
    rd(IDX_CRC_TALLY, 8'h00);
    rd(IDX_FAR_TALLY, 8'h00);
    framer_state_i <= framer_errored_state;
    repeat (254) fr(1'b1, 8'h00);
    rd(IDX_RX_STATUS_TWO, 8'h00);
    fr(1'b1, 8'h00);
    rd(IDX_RX_STATUS_TWO, 8'h03);
    rd(IDX_RX_STATUS_TWO, 8'h00);
    repeat (3) fr(1'b1, 8'h00);
    rd(IDX_CRC_TALLY, 8'hff);
    rd(IDX_FAR_TALLY, 8'hff);
    rd(IDX_RX_STATUS_TWO, 8'h00);
    // A second reset in mid-run wipes flags and tallies alike
    ev(6'h3f);
    @(posedge clk_i);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    rd(IDX_TX_FLAGS, REG_RESET);
    rd(IDX_CRC_TALLY, REG_RESET);
    repeat (4) @(posedge clk_i);
    end_sim();
  end
endmodule
